// ### rtl/ward_pkg.sv
/*
 Constants shared by both ends of the wire adapter request decoder link.
 Assumes a single clock domain and setup packets delivered as one strobe.
*/
package ward_pkg;
   localparam logic [4:0] RCP_IFACE = 5'h01;
   localparam logic [4:0] RCP_PORT = 5'h04;
   localparam logic [4:0] RCP_PIPE = 5'h05;
   localparam logic [7:0] RT_PIPE_WR = 8'h25;
   localparam logic [7:0] RT_PIPE_RD = 8'ha5;
   localparam logic [7:0] RT_IF_WR = 8'h21;
   localparam logic [7:0] RT_IF_RD = 8'ha1;
   localparam logic [7:0] REQ_GET_STATUS = 8'h00;
   localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
   localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
   localparam logic [7:0] REQ_GET_DESCRIPTOR = 8'h06;
   localparam logic [7:0] REQ_SET_DESCRIPTOR = 8'h07;
   localparam logic [7:0] REQ_PIPE_ABORT = 8'h0e;
   localparam logic [7:0] REQ_PIPE_REINIT = 8'h0f;
   localparam logic [15:0] FS_CTRL_ENABLE = 16'h0001;
   localparam logic [15:0] FS_CTRL_RESET = 16'h0002;
   localparam logic [15:0] FS_PIPE_HOLD = 16'h0001;
   localparam logic [15:0] PIPE_STATUS_LEN = 16'h0001;
   localparam logic [7:0] PIPE_STATE_REPORT_OFS = 8'h00;
   localparam int ST_IDLE_BIT = 0;
   localparam int ST_HOLD_BIT = 1;
   localparam int ST_CFG_BIT = 2;
   localparam logic [7:0] DESC_LEN = 8'h1c;
   localparam logic [3:0] CTRL_RESET_CYCLES = 4'h8;
   typedef enum logic [1:0] {WARD_ACK, WARD_DATA, WARD_STALL} ward_resp_t;
endpackage

// ### rtl/ward_if.sv
/*
 Link between control endpoint (host end) and request decoder (device end).
 Assumes one clock; setup presented as a single-cycle strobe.
*/
`timescale 1ns/100ps
interface ward_if (
   input wire logic clk
);
   logic setup_valid;
   logic [7:0] bm_request_type;
   logic [7:0] b_request;
   logic [15:0] w_value;
   logic [15:0] w_index;
   logic [15:0] w_length;
   logic resp_valid;
   ward_pkg::ward_resp_t resp_kind;
   logic [15:0] resp_len;
   logic [7:0] resp_byte;
   logic [7:0] data_idx;
   modport host (output setup_valid, bm_request_type, b_request, w_value, w_index, w_length,
      output data_idx, input resp_valid, resp_kind, resp_len, resp_byte);
   modport device (input setup_valid, bm_request_type, b_request, w_value, w_index, w_length,
      input data_idx, output resp_valid, resp_kind, resp_len, resp_byte);
endinterface // ward_if

// ### rtl/ward_host_end.sv
/*
 Host end: turns a user command into one setup strobe and collects the answer.
 Assumes the user waits for cmd_done before a new command.
*/
`timescale 1ns/100ps
module ward_host_end (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, low
   ward_if.host link, // Link to device end
   input wire logic configured, // Adapter configured
   input wire logic cmd_valid, // Command strobe
   input wire logic [7:0] cmd_type, // Request type
   input wire logic [7:0] cmd_req, // Request code
   input wire logic [15:0] cmd_value, // wValue
   input wire logic [15:0] cmd_index, // wIndex
   input wire logic [15:0] cmd_length, // wLength
   input wire logic [7:0] cmd_byte_sel, // Data byte wanted
   output logic cmd_ready, // Idle, may take command
   output logic cmd_done, // Answer pulse
   output logic cmd_stall, // Answer was stall
   output logic [15:0] cmd_len, // Returned length
   output logic [7:0] cmd_data // Selected data byte
);
   logic busy_q;
   logic issue;
   assign cmd_ready = !busy_q;
   assign issue = cmd_valid && cmd_ready && configured;
   assign link.setup_valid = issue;
   assign link.bm_request_type = cmd_type;
   assign link.b_request = cmd_req;
   assign link.w_value = cmd_value;
   assign link.w_index = cmd_index;
   assign link.w_length = cmd_length;
   assign link.data_idx = cmd_byte_sel;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cmd_done <= 1'b0;
         cmd_stall <= 1'b0;
         cmd_len <= 16'h0000;
         cmd_data <= 8'h00;
      end else begin
         cmd_done <= busy_q && link.resp_valid;
         if (issue) begin
            busy_q <= 1'b1;
         end else if (link.resp_valid) begin
            busy_q <= 1'b0;
         end
         if (busy_q && link.resp_valid) begin
            cmd_stall <= link.resp_kind == ward_pkg::WARD_STALL;
            cmd_len <= link.resp_len;
            cmd_data <= link.resp_byte;
         end
      end
   end
endmodule // ward_host_end

// ### rtl/ward_device_end.sv
/*
 Device end: decodes class requests, keeps per-pipe state and controller enable.
 Assumes the link sits on the default control endpoint and one request at a time.
*/
`timescale 1ns/100ps
module ward_device_end #(
   parameter int NUM_PIPES = 4,
   parameter int NUM_IFACES = 1,
   parameter logic [7:0] IFACE_BASE = 8'h00
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, low
   ward_if.device link, // Control endpoint side
   input wire logic [NUM_PIPES-1:0] pipe_busy, // Pipe has pending transfers
   input wire logic [NUM_PIPES-1:0] pipe_cfg, // Pipe configured
   input wire logic abort_done, // Engine finished abort reports
   output logic [NUM_PIPES-1:0] pipe_abort, // Abort pulse per pipe
   output logic [NUM_PIPES-1:0] pipe_hold, // Hold flag per pipe
   output logic ctrl_enable, // Host controller enable
   output logic ctrl_reset // Host controller reset
);
   localparam int PW = $clog2(NUM_PIPES);
   logic [NUM_PIPES-1:0] hold_q, hold_d, abort_q, abort_d;
   logic en_q, en_d;
   logic [3:0] rst_cnt_q, rst_cnt_d;
   logic resp_valid_q, resp_valid_d;
   ward_pkg::ward_resp_t resp_kind_q, resp_kind_d, answer_kind;
   logic [15:0] resp_len_q, resp_len_d, answer_len;
   logic [PW-1:0] sel_q, sel_d;
   logic waiting_q, waiting_d;

   // Shorter of the asked length and the length actually held
   function automatic logic [15:0] clip_len(input logic [15:0] asked, input logic [15:0] held);
      return asked > held ? held : asked;
   endfunction

   // Report byte: idle when nothing is pending, reserved bits read as zero
   function automatic logic [7:0] state_byte(input logic cfg, input logic held,
      input logic busy);
      logic [7:0] b;
      b = 8'h00;
      b[ward_pkg::ST_IDLE_BIT] = !busy;
      b[ward_pkg::ST_HOLD_BIT] = held;
      b[ward_pkg::ST_CFG_BIT] = cfg;
      return b;
   endfunction

   wire is_pipe_wr = link.bm_request_type == ward_pkg::RT_PIPE_WR;
   wire is_pipe_rd = link.bm_request_type == ward_pkg::RT_PIPE_RD;
   wire is_if_wr = link.bm_request_type == ward_pkg::RT_IF_WR;
   wire is_if_rd = link.bm_request_type == ward_pkg::RT_IF_RD;
   wire [4:0] recip = link.bm_request_type[4:0];
   wire recip_ok = recip == ward_pkg::RCP_PIPE || recip == ward_pkg::RCP_IFACE
      || recip == ward_pkg::RCP_PORT;
   wire pipe_ok = link.w_index[15:12] == 4'h0 &&
      link.w_index[11:0] < 12'(NUM_PIPES);
   wire [PW-1:0] pidx = link.w_index[PW-1:0];
   wire iface_ok = link.w_index[7:0] >= IFACE_BASE &&
      link.w_index[7:0] < IFACE_BASE + 8'(NUM_IFACES);
   wire len_zero = link.w_length == 16'h0000;
   wire val_zero = link.w_value == 16'h0000;
   wire req_abort = is_pipe_wr && link.b_request == ward_pkg::REQ_PIPE_ABORT;
   wire req_pclr = is_pipe_wr && link.b_request == ward_pkg::REQ_CLEAR_FEATURE;
   wire req_pset = is_pipe_wr && link.b_request == ward_pkg::REQ_SET_FEATURE;
   wire req_pstat = is_pipe_rd && link.b_request == ward_pkg::REQ_GET_STATUS;
   wire req_pdesc = is_pipe_rd && link.b_request == ward_pkg::REQ_GET_DESCRIPTOR;
   wire req_iclr = is_if_wr && link.b_request == ward_pkg::REQ_CLEAR_FEATURE;
   wire req_iset = is_if_wr && link.b_request == ward_pkg::REQ_SET_FEATURE;
   wire ok_abort = req_abort && val_zero && len_zero && pipe_ok;
   wire ok_pstat = req_pstat && val_zero &&
      link.w_length == ward_pkg::PIPE_STATUS_LEN && pipe_ok;
   // Whole of wValue compared, so stray upper bits make the selector unknown
   wire sel_hold = link.w_value == ward_pkg::FS_PIPE_HOLD;
   wire sel_enable = link.w_value == ward_pkg::FS_CTRL_ENABLE;
   wire sel_reset = link.w_value == ward_pkg::FS_CTRL_RESET;
   wire ok_pclr = req_pclr && sel_hold && len_zero && pipe_ok;
   wire ok_pset = req_pset && sel_hold && len_zero && pipe_ok;
   wire ok_pdesc = req_pdesc && link.w_value[7:0] == 8'h00 && pipe_ok;
   wire ok_iclr = req_iclr && sel_enable && len_zero && iface_ok;
   wire ok_iset = req_iset && len_zero && iface_ok && (sel_enable || sel_reset);
   wire ok_any = recip_ok && (ok_abort || ok_pstat || ok_pclr || ok_pset || ok_pdesc ||
      ok_iclr || ok_iset);
   wire take = link.setup_valid && !waiting_q;
   wire do_it = take && ok_any;
   wire [15:0] desc_len = clip_len(link.w_length, 16'(ward_pkg::DESC_LEN));

   assign answer_kind = !ok_any ? ward_pkg::WARD_STALL :
      (ok_pstat || ok_pdesc) ? ward_pkg::WARD_DATA : ward_pkg::WARD_ACK;
   assign answer_len = !ok_any ? 16'h0000 : ok_pstat ? ward_pkg::PIPE_STATUS_LEN :
      ok_pdesc ? desc_len : 16'h0000;

   // Pipe flags change only on an accepted request; errors leave them alone
   always_comb begin
      hold_d = hold_q;
      abort_d = '0;
      if (do_it) begin
         if (ok_abort) abort_d[pidx] = 1'b1;
         if (ok_pclr) hold_d[pidx] = 1'b0;
         if (ok_pset) hold_d[pidx] = 1'b1;
      end
   end

   // A controller reset also drops enable, so it restarts disabled
   always_comb begin
      en_d = en_q;
      rst_cnt_d = rst_cnt_q != 4'h0 ? rst_cnt_q - 4'h1 : 4'h0;
      if (do_it) begin
         if (ok_iclr) en_d = 1'b0;
         if (ok_iset && sel_enable) en_d = 1'b1;
         if (ok_iset && sel_reset) begin
            rst_cnt_d = ward_pkg::CTRL_RESET_CYCLES;
            en_d = 1'b0;
         end
      end
   end

   // Abort holds its answer until the engine has flushed notifications and data
   // Kind and length move only with an answer, so they stand until the next one
   always_comb begin
      waiting_d = waiting_q;
      resp_valid_d = 1'b0;
      resp_kind_d = resp_kind_q;
      resp_len_d = resp_len_q;
      sel_d = take ? pidx : sel_q;
      if (take && ok_abort && recip_ok) begin
         waiting_d = 1'b1;
      end else if (waiting_q) begin
         waiting_d = !abort_done;
         resp_valid_d = abort_done;
         if (abort_done) begin
            resp_kind_d = ward_pkg::WARD_ACK;
            resp_len_d = 16'h0000;
         end
      end else if (take) begin
         resp_valid_d = 1'b1;
         resp_kind_d = answer_kind;
         resp_len_d = answer_len;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= '0;
         abort_q <= '0;
      end else begin
         hold_q <= hold_d;
         abort_q <= abort_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= 1'b0;
         rst_cnt_q <= 4'h0;
      end else begin
         en_q <= en_d;
         rst_cnt_q <= rst_cnt_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid_q <= 1'b0;
         resp_kind_q <= ward_pkg::WARD_ACK;
         resp_len_q <= 16'h0000;
         sel_q <= '0;
         waiting_q <= 1'b0;
      end else begin
         resp_valid_q <= resp_valid_d;
         resp_kind_q <= resp_kind_d;
         resp_len_q <= resp_len_d;
         sel_q <= sel_d;
         waiting_q <= waiting_d;
      end
   end

   // Status byte of the last addressed pipe at byte 0 of any 1-byte answer; other descriptor bytes are a plain index pattern
   wire [7:0] state_report = state_byte(pipe_cfg[sel_q], hold_q[sel_q], pipe_busy[sel_q]);
   wire report_byte = resp_len_q == ward_pkg::PIPE_STATUS_LEN &&
      link.data_idx == ward_pkg::PIPE_STATE_REPORT_OFS;
   assign link.resp_valid = resp_valid_q;
   assign link.resp_kind = resp_kind_q;
   assign link.resp_len = resp_len_q;
   assign link.resp_byte = report_byte ? state_report : link.data_idx;
   assign pipe_abort = abort_q;
   assign pipe_hold = hold_q;
   assign ctrl_enable = en_q;
   assign ctrl_reset = rst_cnt_q != 4'h0;
endmodule // ward_device_end

// ### test/ward_link_chk.sv
/*
 Assertions on the request link between the host end and the device end.
 Assumes one clock, async low reset, one interface numbered 0. */
`timescale 1ns/100ps
module ward_link_chk #(parameter int NUM_PIPES = 4) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, low
   input wire logic setup_valid, // Setup strobe
   input wire logic [7:0] bm_request_type, // Request type
   input wire logic [7:0] b_request, // Request code
   input wire logic [15:0] w_value, // wValue
   input wire logic [15:0] w_index, // wIndex
   input wire logic [15:0] w_length, // wLength
   input wire logic [7:0] data_idx, // Byte wanted
   input wire logic resp_valid, // Answer pulse
   input wire ward_pkg::ward_resp_t resp_kind, // Answer kind
   input wire logic [15:0] resp_len, // Answer length
   input wire logic [7:0] resp_byte // Answer byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire pr = setup_valid && bm_request_type == ward_pkg::RT_PIPE_RD;
   wire pw = setup_valid && bm_request_type == ward_pkg::RT_PIPE_WR;
   wire iw = setup_valid && bm_request_type == ward_pkg::RT_IF_WR;
   wire okp = w_index < NUM_PIPES;
   wire st = pr && b_request == ward_pkg::REQ_GET_STATUS;
   wire dr = pr && b_request == ward_pkg::REQ_GET_DESCRIPTOR;
   wire ab = pw && b_request == ward_pkg::REQ_PIPE_ABORT;
   wire cf = b_request == ward_pkg::REQ_CLEAR_FEATURE;
   wire rsv = b_request inside {8'h02, 8'h04, 8'h05, [8'h08:8'h0d]};
   wire stl = resp_valid && resp_kind == ward_pkg::WARD_STALL;
   wire sok = st && w_value == 16'h0 && w_length == 16'h1 && okp;
   wire abok = ab && w_value == 16'h0 && w_length == 16'h0 && okp;
   wire dok = dr && w_value[7:0] == 8'h0 && okp;
   // Clipped length kept combinational so $past can carry it one cycle
   wire [15:0] dlen = w_length > 16'h1c ? 16'h1c : w_length;
   property p_stat; sok |=> resp_valid && resp_kind == ward_pkg::WARD_DATA && resp_len == 16'h1; endproperty
   a_stat: assert property (p_stat) else $error("status read answer wrong");
   property p_stbad; st && !sok |=> stl; endproperty
   a_stbad: assert property (p_stbad) else $error("bad status read not stalled");
   property p_abbad; ab && !abok |=> stl; endproperty
   a_abbad: assert property (p_abbad) else $error("bad abort not stalled");
   property p_desc; dok |=> resp_valid && resp_len == $past(dlen); endproperty
   a_desc: assert property (p_desc) else $error("descriptor length wrong");
   property p_dbad; dr && w_value[7:0] != 8'h0 |=> stl; endproperty
   a_dbad: assert property (p_dbad) else $error("bad descriptor read not stalled");
   property p_rsv; setup_valid && (bm_request_type[4:0] > 5'h5 || rsv) |=> stl; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved code not stalled");
   property p_clr; cf && (pw || iw) && w_value != 16'h1 |=> stl; endproperty
   a_clr: assert property (p_clr) else $error("bad clear selector not stalled");
   property p_ifn; iw && w_index[7:0] != 8'h0 |=> stl; endproperty
   a_ifn: assert property (p_ifn) else $error("unknown interface not stalled");
   property p_rbits; sok ##1 data_idx == 8'h00 |-> resp_byte[7:3] == 5'h00; endproperty
   a_rbits: assert property (p_rbits) else $error("status reserved bits set");
   c_stat: cover property (sok ##1 resp_valid);
   c_abort: cover property (abok);
   c_stall: cover property (stl);
endmodule // ward_link_chk

// ### test/test_wire_adapter_request_decoder.sv
/*
 Bench joining host end and device end over ward_if, with a small abort engine.
 Assumes package, interface and both ends compiled first; 10 MHz clock. */
`timescale 1ns/100ps
module test_wire_adapter_request_decoder;
   localparam logic [25:0] STL = 26'h1000000;
   logic clk = 1'b0, rst_n = 1'b0, configured = 1'b0, cmd_valid = 1'b0, abort_done = 1'b0;
   logic cmd_ready, cmd_done, cmd_stall, ctrl_enable, ctrl_reset;
   logic [7:0] cmd_type = 8'h0, cmd_req = 8'h0, cmd_data;
   logic [15:0] cmd_value = 16'h0, cmd_index = 16'h0, cmd_length = 16'h0, cmd_len;
   logic [3:0] pipe_busy = 4'h0, pipe_cfg = 4'h0, pipe_abort, pipe_hold, ab_exp = 4'h0, hx = 4'h0;
   logic [2:0] ad_q = 3'h0;
   logic [25:0] e, expq[$];
   logic [31:0] rnd = 32'h5e06;
   logic [15:0] dl[4] = '{16'h0, 16'h5, 16'h1c, 16'h28};
   int mismatches = 0, comparisons = 0, rcnt = 0;
   always #50 clk = ~clk;
   ward_if lk (.clk(clk));
   ward_host_end i_ward_host_end (.clk(clk), .rst_n(rst_n), .link(lk), .configured(configured),
      .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_req(cmd_req), .cmd_value(cmd_value),
      .cmd_index(cmd_index), .cmd_length(cmd_length), .cmd_byte_sel(8'h0), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .cmd_stall(cmd_stall), .cmd_len(cmd_len), .cmd_data(cmd_data));
   ward_device_end i_ward_device_end (.clk(clk), .rst_n(rst_n), .link(lk), .pipe_busy(pipe_busy),
      .pipe_cfg(pipe_cfg), .abort_done(abort_done), .pipe_abort(pipe_abort),
      .pipe_hold(pipe_hold), .ctrl_enable(ctrl_enable), .ctrl_reset(ctrl_reset));
   ward_link_chk #(.NUM_PIPES(4)) chk (.clk(clk), .rst_n(rst_n), .setup_valid(lk.setup_valid),
      .bm_request_type(lk.bm_request_type), .b_request(lk.b_request), .w_value(lk.w_value),
      .w_index(lk.w_index), .w_length(lk.w_length), .data_idx(lk.data_idx),
      .resp_valid(lk.resp_valid), .resp_kind(lk.resp_kind), .resp_len(lk.resp_len),
      .resp_byte(lk.resp_byte));
   function automatic logic [31:0] nx();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction
   function automatic logic [25:0] sx(input int p);
      return {2'b10, 16'h1, 5'h0, pipe_cfg[p], hx[p], ~pipe_busy[p]};
   endfunction
   task automatic chk_v(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic req(input logic [7:0] t, q, input logic [15:0] v, x, l, input logic [25:0] w);
      int n;
      expq.push_back(w);
      @(posedge clk);
      {cmd_type, cmd_req, cmd_value, cmd_index, cmd_length, cmd_valid} <= {t, q, v, x, l, 1'b1};
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (n = 0; n < 60 && cmd_done !== 1'b1; n++) @(posedge clk);
      if (n == 60) begin
         mismatches++;
         conclude();
      end
   endtask
   always @(posedge clk) begin
      if (cmd_done === 1'b1 && expq.size() == 0) begin
         mismatches++;
         $display("CHECK FAILED answer expected none seen %h", cmd_len);
      end else if (cmd_done === 1'b1) begin
         e = expq.pop_front();
         chk_v("stall", e[24], cmd_stall);
         if (!e[24]) chk_v("length", e[23:8], cmd_len);
         if (e[25]) chk_v("byte", e[7:0], cmd_data);
      end
      if (pipe_abort !== 4'h0) chk_v("abort", ab_exp, pipe_abort);
      if (ctrl_reset === 1'b1) rcnt++;
      // Engine reports a few cycles late so the answer must wait for it
      abort_done <= ad_q == 3'h1;
      ad_q <= pipe_abort !== 4'h0 ? 3'h4 : ad_q - 3'(ad_q != 3'h0);
      if (ad_q == 3'h1) pipe_busy <= pipe_busy & ~ab_exp;
   end
   initial begin
      {pipe_cfg, pipe_busy} <= 8'(nx());
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
      chk_v("ready", 1, cmd_ready);
      configured <= 1'b1;
      for (int i = 0; i < 5; i++)
         req(8'ha5, 8'h00, 16'h0, 16'(i), 16'h1, i < 4 ? sx(i) : STL);
      req(8'ha5, 8'h00, 16'h0, 16'h1, 16'h2, STL);
      for (int i = 0; i < 16; i++)
         if (!(i inside {0, 1, 3, 6, 7, 14, 15}))
            req(8'h25, 8'(i), 16'h0, 16'h0, 16'h0, STL);
      repeat (3) req({3'b101, 5'(6 + nx() % 26)}, 8'h00, 16'h0, 16'h0, 16'h1, STL);
      req(8'ha4, 8'h00, 16'h0, 16'h0, 16'h1, STL);
      foreach (dl[j])
         req(8'ha5, 8'h06, 16'h0, 16'h1, dl[j], {2'b00, (dl[j] > 16'h1c ? 16'h1c : dl[j]), 8'h0});
      req(8'ha5, 8'h06, 16'h1, 16'h1, 16'h8, STL);
      $display("test status, reserved and descriptor done");
      req(8'h25, 8'h03, 16'h1, 16'h2, 16'h0, 26'h0);
      hx = 4'h4;
      req(8'h25, 8'h01, 16'h2, 16'h2, 16'h0, STL);
      req(8'ha5, 8'h00, 16'h0, 16'h2, 16'h1, sx(2));
      chk_v("hold", hx, pipe_hold);
      req(8'h25, 8'h01, 16'h1, 16'h2, 16'h0, 26'h0);
      hx = 4'h0;
      req(8'ha5, 8'h00, 16'h0, 16'h2, 16'h1, sx(2));
      pipe_busy <= 4'hf;
      req(8'h25, 8'h0e, 16'(nx() | 1), 16'h1, 16'h0, STL);
      ab_exp = 4'h2;
      req(8'h25, 8'h0e, 16'h0, 16'h1, 16'h0, 26'h0);
      req(8'ha5, 8'h00, 16'h0, 16'h1, 16'h1, sx(1));
      ab_exp = 4'h0;
      $display("test hold and abort done");
      req(8'h25, 8'h03, 16'h1, 16'h0, 16'h0, 26'h0);
      hx = 4'h1;
      req(8'h21, 8'h03, 16'h1, 16'h0, 16'h0, 26'h0);
      chk_v("enable", 1, ctrl_enable);
      req(8'h21, 8'h01, 16'h2, 16'h0, 16'h0, STL);
      req(8'h21, 8'h01, 16'h1, 16'h1, 16'h0, STL);
      req(8'h21, 8'h01, 16'h1, 16'h0, 16'h4, STL);
      chk_v("enable", 1, ctrl_enable);
      req(8'h21, 8'h01, 16'h1, 16'h0, 16'h0, 26'h0);
      chk_v("enable", 0, ctrl_enable);
      rcnt = 0;
      req(8'h21, 8'h03, 16'h2, 16'h0, 16'h0, 26'h0);
      repeat (12) @(posedge clk);
      chk_v("reset length", 8, rcnt);
      chk_v("hold", hx, pipe_hold);
      $display("test controller done");
      conclude();
   end
endmodule // test_wire_adapter_request_decoder
